// File: pmu_regs_pkg.sv
// Register map, reset values, field layouts and timing for the regulator register bank
package pmu_regs_pkg;
  localparam logic [7:0] ADDR_SYS_CTL = 8'h00;
  localparam logic [7:0] ADDR_SCRATCH = 8'h01;
  localparam logic [7:0] ADDR_C1_PRI  = 8'h20;
  localparam logic [7:0] ADDR_C1_SEC  = 8'h21;
  localparam logic [7:0] ADDR_C1_CTL  = 8'h22;
  localparam logic [7:0] ADDR_C2_PRI  = 8'h30;
  localparam logic [7:0] ADDR_C2_SEC  = 8'h31;

  localparam logic [7:0] RST_SYS_CTL = 8'h47;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_C1_VOLT = 8'h39;
  localparam logic [7:0] RST_C1_CTL  = 8'h00;
  localparam logic [7:0] RST_C2_VOLT = 8'h1A;

  localparam int VCODE_W   = 6;
  localparam int LEV_W     = 4;
  localparam int SCRATCH_W = 4;
  localparam int DELAY_W   = 3;
  localparam int RCNT_W    = 24;

  localparam longint CLK_HZ        = 50_000_000;
  localparam longint RST_SHORT_MS  = 65;
  localparam longint RST_LONG_MS   = 260;
  localparam longint RST_SHORT_CYC = RST_SHORT_MS * CLK_HZ / 1000;
  localparam longint RST_LONG_CYC  = RST_LONG_MS * CLK_HZ / 1000;

  // Serial target address; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h5B;

  typedef struct packed {
    logic             rst_short;
    logic             irq_mode;
    logic             unmask;
    logic             below;
    logic [LEV_W-1:0] lev;
  } sys_ctl_t;

  typedef struct packed {
    logic               on;
    logic               phase;
    logic               pwm;
    logic [DELAY_W-1:0] delay;
    logic               fault_en;
    logic               ok;
  } conv_ctl_t;
endpackage

// File: serial_reg_target.sv
// Two-wire serial target that turns bus traffic into register writes and reads
`timescale 1ns/1ps
module serial_reg_target (
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  input  wire logic       i_scl,
  input  wire logic       i_sda_in,
  output logic            o_sda_out,
  output logic            o_sda_oe_n,
  output logic            o_wr_en,
  output logic [7:0]      o_wr_addr,
  output logic [7:0]      o_wr_data,
  output logic [7:0]      o_rd_addr,
  input  wire logic [7:0] i_rd_data
);
  typedef enum logic [3:0] {IDLE, DEVA, ACKD, REGA, ACKR, WRD, ACKW, RDD, RDACK} st_t;

  logic [1:0] p_s1, p_s2, p_s3, p_f, p_prev;
  st_t        st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, addr_q, addr_d, wdat_q, wdat_d;
  logic       rw_q, rw_d, drv_q, drv_d, wen_q, wen_d;
  logic       scl, sda, rise, fall, start, stop;

  // Pin filter: a level is taken once stages two and three agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        p_s1[g]   <= 1'b1;
        p_s2[g]   <= 1'b1;
        p_s3[g]   <= 1'b1;
        p_f[g]    <= 1'b1;
        p_prev[g] <= 1'b1;
      end else if (i_ce) begin
        p_s1[g]   <= g == 0 ? i_scl : i_sda_in;
        p_s2[g]   <= p_s1[g];
        p_s3[g]   <= p_s2[g];
        p_f[g]    <= (p_s2[g] == p_s3[g]) ? p_s3[g] : p_f[g];
        p_prev[g] <= p_f[g];
      end
    end
  end

  assign scl   = p_f[0];
  assign sda   = p_f[1];
  assign rise  = scl & ~p_prev[0];
  assign fall  = ~scl & p_prev[0];
  assign start = scl & p_prev[0] & p_prev[1] & ~sda;
  assign stop  = scl & p_prev[0] & ~p_prev[1] & sda;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rw_d   = rw_q;
    drv_d  = drv_q;
    wen_d  = 1'b0;
    if (stop) begin
      st_d  = IDLE;
      drv_d = 1'b0;
    end else if (start) begin
      st_d  = DEVA;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        DEVA, REGA, WRD: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            drv_d = 1'b1;
            if (st_q == DEVA) begin
              rw_d = sh_q[0];
              st_d = ACKD;
              if (sh_q[7:1] != pmu_regs_pkg::DEV_ADDR) begin
                st_d  = IDLE;
                drv_d = 1'b0;
              end
            end else if (st_q == REGA) begin
              addr_d = sh_q;
              st_d   = ACKR;
            end else begin
              wdat_d = sh_q;
              wen_d  = 1'b1;
              st_d   = ACKW;
            end
          end
        end
        ACKD: begin
          if (fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              sh_d  = i_rd_data;
              drv_d = ~i_rd_data[7];
              st_d  = RDD;
            end else begin
              drv_d = 1'b0;
              st_d  = REGA;
            end
          end
        end
        ACKR, ACKW: begin
          if (fall) begin
            drv_d = 1'b0;
            cnt_d = 4'h0;
            st_d  = WRD;
            if (st_q == ACKW) begin
              addr_d = addr_q + 8'h01;
            end
          end
        end
        RDD: begin
          if (rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            drv_d  = 1'b0;
            addr_d = addr_q + 8'h01;
            st_d   = RDACK;
          end else if (fall && cnt_q != 4'h0) begin
            sh_d  = {sh_q[6:0], 1'b0};
            drv_d = ~sh_q[6];
          end
        end
        RDACK: begin
          if (rise && sda) begin
            st_d = IDLE;
          end else if (fall) begin
            sh_d  = i_rd_data;
            drv_d = ~i_rd_data[7];
            cnt_d = 4'h0;
            st_d  = RDD;
          end
        end
        default: st_d = IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_q   <= IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      addr_q <= 8'h00;
      wdat_q <= 8'h00;
      rw_q   <= 1'b0;
      drv_q  <= 1'b0;
      wen_q  <= 1'b0;
    end else if (i_ce) begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rw_q   <= rw_d;
      drv_q  <= drv_d;
      wen_q  <= wen_d;
    end
  end

  assign o_sda_out  = 1'b0;
  assign o_sda_oe_n = ~drv_q;
  assign o_wr_en    = wen_q & i_ce;
  assign o_wr_addr  = addr_q;
  assign o_wr_data  = wdat_q;
  assign o_rd_addr  = addr_q;
endmodule

// File: pmu_system_regulator_regs.sv
// System and step-down converter register bank with its control outputs
//
// Function
// - Reset time-out 65 ms if set, else 260 ms
// - Low supply: interrupt if mode set, else shutdown
// - Supply interrupt masked at reset; 1 unmasks
// - Status bit reads 1 while supply below threshold
// - Low four bits choose the supply threshold
// - Four scratch bits store writes, no effect
// - Scratch bits clear on undervoltage lockout
// - Primary voltage code used while select low
// - Secondary voltage code used while select high
// - Enable bit turns the converter on
// - Phase bit selects 180 degree switching
// - Mode bit forces PWM at every load
// - Three-bit field selects turn-on delay
// - Fault mask bit set enables fault interrupt
// - Power-good bit reflects the converter output
// - Undervoltage lockout returns all bits to default
`timescale 1ns/1ps
module pmu_system_regulator_regs #(
  parameter int unsigned RST_SHORT_CYCLES = int'(pmu_regs_pkg::RST_SHORT_CYC),
  parameter int unsigned RST_LONG_CYCLES  = int'(pmu_regs_pkg::RST_LONG_CYC)
) (
  input  wire logic                            i_clk_sys,
  input  wire logic                            i_srst,
  input  wire logic                            i_ce,
  input  wire logic                            i_scl,
  input  wire logic                            i_sda_in,
  output logic                                 o_sda_out,
  output logic                                 o_sda_oe_n,
  input  wire logic                            i_voltage_select_pin,
  input  wire logic                            i_supply_below_threshold,
  input  wire logic                            i_uvlo,
  input  wire logic                            i_conv1_power_good,
  input  wire logic                            i_conv1_fault,
  output logic                                 o_reset_output_n,
  output logic [pmu_regs_pkg::LEV_W-1:0]       o_supply_threshold,
  output logic                                 o_supply_irq,
  output logic                                 o_shutdown_req,
  output logic                                 o_conv1_enable,
  output logic                                 o_conv1_phase_180,
  output logic                                 o_conv1_forced_pwm,
  output logic [pmu_regs_pkg::DELAY_W-1:0]     o_conv1_on_delay,
  output logic                                 o_conv1_fault_irq,
  output logic [pmu_regs_pkg::VCODE_W-1:0]     o_conv1_voltage_code,
  output logic [pmu_regs_pkg::VCODE_W-1:0]     o_conv2_voltage_code
);
  localparam int NPIN = 5;
  localparam int unsigned SHORT_M1 = RST_SHORT_CYCLES - 1;
  localparam int unsigned LONG_M1  = RST_LONG_CYCLES - 1;

  logic [NPIN-1:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_f;
  logic            voltage_select_pin_s, below_s, uvlo_s, pgood_s, fault_s;

  pmu_regs_pkg::sys_ctl_t  sys_q, sys_d;
  pmu_regs_pkg::conv_ctl_t ctl_q, ctl_d;
  logic [pmu_regs_pkg::SCRATCH_W-1:0] scr_q, scr_d;
  logic [pmu_regs_pkg::VCODE_W-1:0]   c1_pri_q, c1_pri_d, c1_sec_q, c1_sec_d;
  logic [pmu_regs_pkg::VCODE_W-1:0]   c2_pri_q, c2_pri_d, c2_sec_q, c2_sec_d;

  logic [pmu_regs_pkg::RCNT_W-1:0] rcnt_q, rcnt_d, rlimit;
  logic                            rdone_q, rdone_d;

  logic                               irq_q, irq_d, shdn_q, shdn_d, firq_q, firq_d;
  logic [pmu_regs_pkg::VCODE_W-1:0]   code1_q, code1_d, code2_q, code2_d;

  logic       wr_en;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;

  serial_reg_target u_target (
    .i_clk_sys  (i_clk_sys),
    .i_srst     (i_srst),
    .i_ce       (i_ce),
    .i_scl      (i_scl),
    .i_sda_in   (i_sda_in),
    .o_sda_out  (o_sda_out),
    .o_sda_oe_n (o_sda_oe_n),
    .o_wr_en    (wr_en),
    .o_wr_addr  (wr_addr),
    .o_wr_data  (wr_data),
    .o_rd_addr  (rd_addr),
    .i_rd_data  (rd_data)
  );

  // Analog and pin inputs: a change is taken once stages two and three agree
  assign pin_raw = {i_conv1_fault, i_conv1_power_good, i_uvlo, i_supply_below_threshold, i_voltage_select_pin};

  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        pin_s1[g] <= 1'b0;
        pin_s2[g] <= 1'b0;
        pin_s3[g] <= 1'b0;
        pin_f[g]  <= 1'b0;
      end else if (i_ce) begin
        pin_s1[g] <= pin_raw[g];
        pin_s2[g] <= pin_s1[g];
        pin_s3[g] <= pin_s2[g];
        pin_f[g]  <= (pin_s2[g] == pin_s3[g]) ? pin_s3[g] : pin_f[g];
      end
    end
  end

  assign {fault_s, pgood_s, uvlo_s, below_s, voltage_select_pin_s} = pin_f;

  // Register file
  always_comb begin
    sys_d    = sys_q;
    scr_d    = scr_q;
    c1_pri_d = c1_pri_q;
    c1_sec_d = c1_sec_q;
    ctl_d    = ctl_q;
    c2_pri_d = c2_pri_q;
    c2_sec_d = c2_sec_q;
    // Lockout wins over a write that lands in the same cycle
    if (uvlo_s) begin
      sys_d    = pmu_regs_pkg::RST_SYS_CTL;
      scr_d    = pmu_regs_pkg::RST_SCRATCH[3:0];
      c1_pri_d = pmu_regs_pkg::RST_C1_VOLT[5:0];
      c1_sec_d = pmu_regs_pkg::RST_C1_VOLT[5:0];
      ctl_d    = pmu_regs_pkg::RST_C1_CTL;
      c2_pri_d = pmu_regs_pkg::RST_C2_VOLT[5:0];
      c2_sec_d = pmu_regs_pkg::RST_C2_VOLT[5:0];
    end else if (wr_en) begin
      case (wr_addr)
        pmu_regs_pkg::ADDR_SYS_CTL: begin
          sys_d       = wr_data;
          sys_d.below = 1'b0;
        end
        pmu_regs_pkg::ADDR_SCRATCH: scr_d = wr_data[3:0];
        pmu_regs_pkg::ADDR_C1_PRI:  c1_pri_d = wr_data[5:0];
        pmu_regs_pkg::ADDR_C1_SEC:  c1_sec_d = wr_data[5:0];
        pmu_regs_pkg::ADDR_C1_CTL: begin
          ctl_d    = wr_data;
          ctl_d.ok = 1'b0;
        end
        pmu_regs_pkg::ADDR_C2_PRI:  c2_pri_d = wr_data[5:0];
        pmu_regs_pkg::ADDR_C2_SEC:  c2_sec_d = wr_data[5:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sys_q    <= pmu_regs_pkg::RST_SYS_CTL;
      scr_q    <= pmu_regs_pkg::RST_SCRATCH[3:0];
      c1_pri_q <= pmu_regs_pkg::RST_C1_VOLT[5:0];
      c1_sec_q <= pmu_regs_pkg::RST_C1_VOLT[5:0];
      ctl_q    <= pmu_regs_pkg::RST_C1_CTL;
      c2_pri_q <= pmu_regs_pkg::RST_C2_VOLT[5:0];
      c2_sec_q <= pmu_regs_pkg::RST_C2_VOLT[5:0];
    end else if (i_ce) begin
      sys_q    <= sys_d;
      scr_q    <= scr_d;
      c1_pri_q <= c1_pri_d;
      c1_sec_q <= c1_sec_d;
      ctl_q    <= ctl_d;
      c2_pri_q <= c2_pri_d;
      c2_sec_q <= c2_sec_d;
    end
  end

  // Read path; live status bits come straight from the filtered inputs
  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      pmu_regs_pkg::ADDR_SYS_CTL: rd_data = {sys_q.rst_short, sys_q.irq_mode, sys_q.unmask, below_s, sys_q.lev};
      pmu_regs_pkg::ADDR_SCRATCH: rd_data = {4'h0, scr_q};
      pmu_regs_pkg::ADDR_C1_PRI:  rd_data = {2'h0, c1_pri_q};
      pmu_regs_pkg::ADDR_C1_SEC:  rd_data = {2'h0, c1_sec_q};
      pmu_regs_pkg::ADDR_C1_CTL:  rd_data = {ctl_q[7:1], pgood_s};
      pmu_regs_pkg::ADDR_C2_PRI:  rd_data = {2'h0, c2_pri_q};
      pmu_regs_pkg::ADDR_C2_SEC:  rd_data = {2'h0, c2_sec_q};
      default: rd_data = 8'h00;
    endcase
  end

  // Reset time-out: restarts on lockout, then releases the reset output
  assign rlimit = sys_q.rst_short ? SHORT_M1[pmu_regs_pkg::RCNT_W-1:0]
                                  : LONG_M1[pmu_regs_pkg::RCNT_W-1:0];

  always_comb begin
    rcnt_d  = rcnt_q;
    rdone_d = rdone_q;
    if (uvlo_s) begin
      rcnt_d  = '0;
      rdone_d = 1'b0;
    end else if (!rdone_q) begin
      if (rcnt_q >= rlimit) begin
        rdone_d = 1'b1;
      end else begin
        rcnt_d = rcnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rcnt_q  <= '0;
      rdone_q <= 1'b0;
    end else if (i_ce) begin
      rcnt_q  <= rcnt_d;
      rdone_q <= rdone_d;
    end
  end

  // Registered control outputs
  always_comb begin
    irq_d   = below_s & sys_q.irq_mode & sys_q.unmask;
    shdn_d  = below_s & ~sys_q.irq_mode;
    firq_d  = fault_s & ctl_q.fault_en;
    code1_d = voltage_select_pin_s ? c1_sec_q : c1_pri_q;
    code2_d = voltage_select_pin_s ? c2_sec_q : c2_pri_q;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      irq_q   <= 1'b0;
      shdn_q  <= 1'b0;
      firq_q  <= 1'b0;
      code1_q <= pmu_regs_pkg::RST_C1_VOLT[5:0];
      code2_q <= pmu_regs_pkg::RST_C2_VOLT[5:0];
    end else if (i_ce) begin
      irq_q   <= irq_d;
      shdn_q  <= shdn_d;
      firq_q  <= firq_d;
      code1_q <= code1_d;
      code2_q <= code2_d;
    end
  end

  assign o_reset_output_n     = rdone_q;
  assign o_supply_threshold   = sys_q.lev;
  assign o_supply_irq         = irq_q;
  assign o_shutdown_req       = shdn_q;
  assign o_conv1_enable       = ctl_q.on;
  assign o_conv1_phase_180    = ctl_q.phase;
  assign o_conv1_forced_pwm   = ctl_q.pwm;
  assign o_conv1_on_delay     = ctl_q.delay;
  assign o_conv1_fault_irq    = firq_q;
  assign o_conv1_voltage_code = code1_q;
  assign o_conv2_voltage_code = code2_q;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  // The limit follows the select bit live, so a shorter limit may release past its count
  chk_reset_timeout: assert property ($rose(rdone_q) |-> $past(rcnt_q) >= $past(rlimit))
    else $error("reset output released before its count");
  chk_reset_release: assert property (i_ce && !uvlo_s && !rdone_q && rcnt_q >= rlimit
      |=> o_reset_output_n)
    else $error("reset output not released at its count");
  chk_reset_early: assert property (i_ce && !rdone_q && rcnt_q < rlimit |=> !o_reset_output_n)
    else $error("reset output released early");

  // Supply monitor response
  chk_shutdown_resp: assert property (i_ce && below_s && !sys_q.irq_mode |=> o_shutdown_req && !o_supply_irq)
    else $error("shutdown response missing");
  chk_irq_response: assert property (i_ce && below_s && sys_q.irq_mode && sys_q.unmask
      |=> o_supply_irq && !o_shutdown_req)
    else $error("supply interrupt missing");
  chk_monitor_idle: assert property (i_ce && !below_s |=> !o_supply_irq && !o_shutdown_req)
    else $error("monitor response without low supply");
  chk_irq_masked: assert property (i_ce && !sys_q.unmask |=> !o_supply_irq)
    else $error("masked supply interrupt raised");
  chk_status_read: assert property (rd_addr == pmu_regs_pkg::ADDR_SYS_CTL |-> rd_data[4] == below_s)
    else $error("status bit differs from supply state");

  // Register writes and lockout
  chk_threshold_write: assert property (i_ce && wr_en && !uvlo_s && wr_addr == pmu_regs_pkg::ADDR_SYS_CTL
      |=> {4'h0, o_supply_threshold} == ($past(wr_data) & 8'h0F))
    else $error("threshold not taken from write");
  chk_scratch_write: assert property (i_ce && wr_en && !uvlo_s && wr_addr == pmu_regs_pkg::ADDR_SCRATCH
      |=> {4'h0, scr_q} == ($past(wr_data) & 8'h0F))
    else $error("scratch bits not stored");
  chk_ctl_write: assert property (i_ce && wr_en && !uvlo_s && wr_addr == pmu_regs_pkg::ADDR_C1_CTL
      |=> {2'h0, o_conv1_enable, o_conv1_phase_180, o_conv1_forced_pwm, o_conv1_on_delay}
          == ($past(wr_data) >> 2))
    else $error("converter controls not taken from write");
  chk_uvlo_clear: assert property (i_ce && uvlo_s |=> scr_q == 4'h0 && ctl_q == 8'h00 && !rdone_q)
    else $error("lockout did not clear state");
  chk_uvlo_defaults: assert property (i_ce && uvlo_s |=> sys_q == pmu_regs_pkg::RST_SYS_CTL
      && c1_sec_q == pmu_regs_pkg::RST_C1_VOLT[5:0] && c2_pri_q == pmu_regs_pkg::RST_C2_VOLT[5:0])
    else $error("lockout did not restore defaults");

  // Converter outputs
  chk_voltage_select_pin_code: assert property (i_ce |=> o_conv1_voltage_code ==
      ($past(voltage_select_pin_s) ? $past(c1_sec_q) : $past(c1_pri_q)))
    else $error("wrong voltage code selected");
  chk_conv2_code: assert property (i_ce |=> o_conv2_voltage_code ==
      ($past(voltage_select_pin_s) ? $past(c2_sec_q) : $past(c2_pri_q)))
    else $error("wrong second converter code");
  chk_fault_mask: assert property (i_ce && !ctl_q.fault_en |=> !o_conv1_fault_irq)
    else $error("fault interrupt while disabled");
  chk_fault_response: assert property (i_ce && fault_s && ctl_q.fault_en |=> o_conv1_fault_irq)
    else $error("enabled fault interrupt missing");
  chk_reserved_zero: assert property (rd_addr == pmu_regs_pkg::ADDR_C1_PRI |-> rd_data[7:6] == 2'h0)
    else $error("reserved bits read nonzero");

  cov_ctl_write: cover property (wr_en && wr_addr == pmu_regs_pkg::ADDR_C1_CTL);
  cov_reset_release: cover property ($rose(rdone_q));
  cov_supply_irq: cover property ($rose(o_supply_irq));
  cov_shutdown: cover property ($rose(o_shutdown_req));
  cov_voltage_select_pin_high: cover property (voltage_select_pin_s && o_conv1_voltage_code == c1_sec_q);
endmodule

// File: pmu_host_model.sv
// Host model: two-wire serial master with open-drain data line and pull-up
`timescale 1ns/1ps
module pmu_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Each bus level is held well beyond the pin filter depth
  localparam int HALF = 8;

  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask

  // Also serves as repeated start when the clock line is low
  task automatic start_cond();
    wt(2);
    o_sda_low = 1'b0;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_low = 1'b1;
    wt(HALF);
    o_scl = 1'b0;
  endtask

  task automatic stop_cond();
    wt(2);
    o_sda_low = 1'b1;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_low = 1'b0;
    wt(HALF);
  endtask

  // Data moves only while the clock line is low, a few cycles after its fall
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    o_sda_low = ~b;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    r = i_sda;
    o_scl = 1'b0;
  endtask

  // Nine clocks: eight data bits MSB first, then the line is released for the answer
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic write_reg(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    start_cond();
    xfer({dv, 1'b0}, q, a0);
    xfer(a, q, a1);
    xfer(d, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Single-byte read, ended with a NACK from the pull-up
  task automatic read_reg(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       nk;
    start_cond();
    xfer({dv, 1'b0}, q, a0);
    xfer(a, q, a1);
    start_cond();
    xfer({dv, 1'b1}, q, a2);
    xfer(8'hFF, d, nk);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule

// File: tb_top.sv
// Self-checking testbench for the regulator register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  localparam int SHORT = 20;
  localparam int LONG  = 1500;
  logic       clk = 1'b0;
  logic       ce = 1'b1;
  logic       srst;
  logic       below;
  logic       uvlo;
  logic       sel;
  logic       pg;
  logic       fault;
  logic       scl;
  logic       host_low;
  logic       sda_out;
  logic       sda_oe_n;
  logic       rst_n;
  logic [3:0] thr;
  logic       irq;
  logic       sd;
  logic       en;
  logic       ph;
  logic       pwm;
  logic [2:0] dly;
  logic       firq;
  logic [5:0] c1;
  logic [5:0] c2;
  logic       ok;
  int         bad_count = 0;
  int         num_checks = 0;
  logic [7:0] cfg [4] = '{8'h47, 8'h67, 8'h28, 8'h2B};
  logic [1:0] ex [4] = '{2'b00, 2'b10, 2'b01, 2'b01};
  wire        sda = ~(host_low | (~sda_oe_n & ~sda_out));

  always #10 clk = ~clk;

  pmu_host_model host_u (
    .i_clk_sys (clk),
    .i_sda     (sda),
    .o_scl     (scl),
    .o_sda_low (host_low)
  );

  pmu_system_regulator_regs #(
    .RST_SHORT_CYCLES (SHORT),
    .RST_LONG_CYCLES  (LONG)
  ) dut_u (
    .i_clk_sys                (clk),
    .i_srst                   (srst),
    .i_ce                     (ce),
    .i_scl                    (scl),
    .i_sda_in                 (sda),
    .o_sda_out                (sda_out),
    .o_sda_oe_n               (sda_oe_n),
    .i_voltage_select_pin     (sel),
    .i_supply_below_threshold (below),
    .i_uvlo                   (uvlo),
    .i_conv1_power_good       (pg),
    .i_conv1_fault            (fault),
    .o_reset_output_n         (rst_n),
    .o_supply_threshold       (thr),
    .o_supply_irq             (irq),
    .o_shutdown_req           (sd),
    .o_conv1_enable           (en),
    .o_conv1_phase_180        (ph),
    .o_conv1_forced_pwm       (pwm),
    .o_conv1_on_delay         (dly),
    .o_conv1_fault_irq        (firq),
    .o_conv1_voltage_code     (c1),
    .o_conv2_voltage_code     (c2)
  );

  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    host_u.write_reg(pmu_regs_pkg::DEV_ADDR, a, d, k);
    `CHK("write ack", 1'b1, k)
    cyc(4);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       k;
    host_u.read_reg(pmu_regs_pkg::DEV_ADDR, a, d, k);
    `CHK("read ack", 1'b1, k)
    `CHK($sformatf("register %h", a), e, d)
  endtask

  task automatic do_reset();
    srst = 1'b1;
    cyc(6);
    srst = 1'b0;
    cyc(10);
  endtask

  task automatic defaults();
    rd(pmu_regs_pkg::ADDR_SYS_CTL, pmu_regs_pkg::RST_SYS_CTL);
    rd(pmu_regs_pkg::ADDR_SCRATCH, pmu_regs_pkg::RST_SCRATCH);
    rd(pmu_regs_pkg::ADDR_C1_PRI, pmu_regs_pkg::RST_C1_VOLT);
    rd(pmu_regs_pkg::ADDR_C1_SEC, pmu_regs_pkg::RST_C1_VOLT);
    rd(pmu_regs_pkg::ADDR_C1_CTL, pmu_regs_pkg::RST_C1_CTL);
    rd(pmu_regs_pkg::ADDR_C2_PRI, pmu_regs_pkg::RST_C2_VOLT);
    rd(pmu_regs_pkg::ADDR_C2_SEC, pmu_regs_pkg::RST_C2_VOLT);
    `CHK("codes", {pmu_regs_pkg::RST_C1_VOLT[5:0], pmu_regs_pkg::RST_C2_VOLT[5:0]}, {c1, c2})
    `CHK("threshold", pmu_regs_pkg::RST_SYS_CTL[3:0], thr)
    `CHK("conv1 controls", 7'h00, {en, ph, pwm, dly, firq})
  endtask

  initial begin
    cyc(90000);
    bad_count++;
    print_verdict();
  end

  initial begin
    {below, uvlo, sel, pg, fault} = 5'h00;
    do_reset();
    `CHK("reset output held", 1'b0, rst_n)
    wr(8'h00, 8'hC7);
    `CHK("short time-out", 1'b1, rst_n)
    do_reset();
    cyc(LONG - 120);
    `CHK("long time-out running", 1'b0, rst_n)
    cyc(200);
    `CHK("long time-out done", 1'b1, rst_n)
    defaults();
    // Supply monitor response for both modes, with the interrupt mode both masked and unmasked
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, cfg[i]);
      below = 1'b1;
      cyc(10);
      `CHK("irq and shutdown", ex[i], {irq, sd})
      `CHK("threshold", cfg[i][3:0], thr)
      rd(8'h00, cfg[i] | 8'h10);
      below = 1'b0;
      cyc(10);
      `CHK("monitor idle", 2'b00, {irq, sd})
      rd(8'h00, cfg[i]);
    end
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h0F);
    host_u.write_reg(pmu_regs_pkg::DEV_ADDR ^ 7'h01, 8'h01, 8'h03, ok);
    `CHK("foreign address ack", 1'b0, ok)
    rd(8'h01, 8'h0F);
    host_u.write_reg(pmu_regs_pkg::DEV_ADDR, 8'h05, 8'h5A, ok);
    `CHK("unmapped write ack", 1'b1, ok)
    rd(8'h05, 8'h00);
    wr(8'h20, 8'hFF);
    wr(8'h21, 8'h05);
    wr(8'h30, 8'hEA);
    wr(8'h31, 8'h15);
    rd(8'h20, 8'h3F);
    rd(8'h30, 8'h2A);
    `CHK("primary codes", {6'h3F, 6'h2A}, {c1, c2})
    // Clock enable low freezes the codes although the select pin moves
    ce = 1'b0;
    sel = 1'b1;
    cyc(10);
    `CHK("frozen codes", {6'h3F, 6'h2A}, {c1, c2})
    ce = 1'b1;
    cyc(10);
    `CHK("secondary codes", {6'h05, 6'h15}, {c1, c2})
    sel = 1'b0;
    cyc(10);
    `CHK("primary again", {6'h3F, 6'h2A}, {c1, c2})
    pg = 1'b1;
    fault = 1'b1;
    wr(8'h22, 8'hFF);
    cyc(10);
    rd(8'h22, 8'hFF);
    `CHK("conv1 all set", 7'h7F, {en, ph, pwm, dly, firq})
    wr(8'h22, 8'hA9);
    pg = 1'b0;
    cyc(10);
    rd(8'h22, 8'hA8);
    `CHK("conv1 mixed", 7'b1010100, {en, ph, pwm, dly, firq})
    wr(8'h22, 8'h4A);
    `CHK("conv1 off", 7'b0100101, {en, ph, pwm, dly, firq})
    fault = 1'b0;
    cyc(10);
    `CHK("fault gone", 1'b0, firq)
    // Lockout returns every register to its default and restarts the time-out
    uvlo = 1'b1;
    cyc(10);
    uvlo = 1'b0;
    cyc(10);
    `CHK("lockout time-out", 1'b0, rst_n)
    defaults();
    print_verdict();
  end
endmodule
